// *** rtl/bus_master_cycle_sequencer.sv ***
// Memory cycle sequencer acting as a bus master, with an AHB-Lite register port
`timescale 1ns/1ps
module bus_master_cycle_sequencer
  import bus_seq_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // System bus handshake
  input wire logic slave_sync,
  output logic master_sync,
  output logic address_drive_enable,
  output logic bus_busy,
  output logic bus_owner_flag,
  output logic sel_ack,
  output logic busy_release,
  output logic buffer_load_strobe,
  // Queue state and error inputs
  input wire logic input_ready,
  input wire logic output_ready,
  input wire logic bus_parity_error,
  input wire logic compare_mismatch_error,
  input wire logic word_count_overflow,
  input wire logic exception_stop
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  seq_state_e state_ff, nxt_state; // Cycle phase
  logic sync1_ff, sync2_ff; // Slave sync synchroniser
  logic master_sync_ff, nxt_master_sync;
  logic addr_en_ff, nxt_addr_en;
  logic busy_ff, nxt_busy;
  logic owner_ff, nxt_owner;
  logic sel_ack_ff, nxt_sel_ack;
  logic release_ff, nxt_release; // Busy release pulse
  logic strobe_ff, nxt_strobe; // Buffer load pulse
  logic second_ff, nxt_second; // Second-transfer flag
  logic next_ff, nxt_next; // Another-transfer flag
  logic nonexistent_memory_flag, nxt_nxm;
  logic transfer_error_bit, nxt_terr;
  logic tmr_load; // Timer reload this cycle
  logic [TIMER_W-1:0] tmr_val;
  logic tmr_expired;
  logic reply_seen; // Synchronised slave sync
  logic is_read, hold_active, word_ready, free_bus;
  // Register port state
  logic [CTL_W-1:0] control_ff, nxt_control;
  logic wr_pend_ff, nxt_wr_pend;
  logic [7:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic start_cmd, error_clear_strobe;

  ////////////////////////////////////////////////////////////////////////////
  // Slave sync crossing and derived terms

  // Slave sync comes from a pin, so two flops before use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= slave_sync;
      sync2_ff <= sync1_ff;
    end
  end

  assign reply_seen = sync2_ff;
  assign is_read = (control_ff[CTL_FN_LSB +: 2] == FN_READ);
  // Hold only counts on bus two without the single option
  assign hold_active = control_ff[CTL_HOLD_BIT] & control_ff[CTL_BUSB_BIT] & ~control_ff[CTL_SINGLE_BIT];
  // Write fills the input side, other functions drain the output side
  assign word_ready = (control_ff[CTL_FN_LSB +: 2] == FN_WRITE) ? input_ready : output_ready;
  // Errors always end ownership, even in hold mode
  assign free_bus = second_ff | ~next_ff | bus_parity_error | compare_mismatch_error;

  ////////////////////////////////////////////////////////////////////////////
  // Phase timer

  cycle_timer #(.W(TIMER_W)) u_timer (
    .clock(clock),
    .rst(rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer next state

  always_comb begin
    nxt_state = state_ff;
    nxt_master_sync = master_sync_ff;
    nxt_addr_en = addr_en_ff;
    nxt_busy = busy_ff;
    nxt_owner = owner_ff;
    nxt_sel_ack = sel_ack_ff;
    nxt_release = 1'b0;
    nxt_strobe = 1'b0;
    nxt_second = second_ff;
    nxt_next = next_ff;
    nxt_nxm = nonexistent_memory_flag;
    nxt_terr = transfer_error_bit;
    tmr_load = 1'b0;
    tmr_val = '0;
    // Software clear first, so a same-cycle error still sets
    if (error_clear_strobe) begin
      nxt_nxm = 1'b0;
      nxt_terr = 1'b0;
    end
    unique case (state_ff)
      ST_IDLE: begin
        // Start raises the acknowledge, next cycle takes the bus
        if (start_cmd) begin
          nxt_sel_ack = 1'b1;
        end
        if (sel_ack_ff) begin
          nxt_sel_ack = 1'b0;
          nxt_owner = 1'b1;
          nxt_busy = 1'b1;
          nxt_addr_en = 1'b1;
          tmr_load = 1'b1;
          tmr_val = TIMER_W'(SETTLE_CYC - 1);
          nxt_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // Address settles first; wait for last reply to drop
        if (tmr_expired && !reply_seen) begin
          nxt_master_sync = 1'b1;
          tmr_load = 1'b1;
          tmr_val = TIMER_W'(REPLY_TIMEOUT_CYC - 1);
          nxt_state = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (reply_seen) begin
          // Reply cancels the timeout outright
          tmr_load = 1'b1;
          if (is_read) begin
            tmr_val = TIMER_W'(SYNC_RELEASE_CYC - 1);
            nxt_state = ST_RELEASE;
          end else begin
            tmr_val = TIMER_W'(DATA_DESKEW_CYC - 1);
            nxt_state = ST_DESKEW;
          end
        end else if (tmr_expired) begin
          // No reply in time: memory missing
          nxt_nxm = 1'b1;
          nxt_terr = 1'b1;
          tmr_load = 1'b1;
          if (is_read) begin
            tmr_val = TIMER_W'(SYNC_RELEASE_CYC - 1);
            nxt_state = ST_RELEASE;
          end else begin
            tmr_val = TIMER_W'(DATA_DESKEW_CYC - 1);
            nxt_state = ST_DESKEW;
          end
        end
      end
      ST_DESKEW: begin
        if (tmr_expired) begin
          tmr_load = 1'b1;
          tmr_val = TIMER_W'(SYNC_RELEASE_CYC - 1);
          nxt_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // Address and busy stay up through this phase
        if (tmr_expired) begin
          tmr_load = 1'b1;
          tmr_val = TIMER_W'(END_CYCLE_CYC - 1);
          nxt_addr_en = 1'b0;
          nxt_state = ST_END;
        end
      end
      ST_END: begin
        if (tmr_expired) begin
          if (free_bus) begin
            // Last cycle: give the bus back
            nxt_busy = 1'b0;
            nxt_owner = 1'b0;
            nxt_release = 1'b1;
            nxt_state = ST_IDLE;
          end else begin
            // Launch the next cycle of the sequence
            nxt_addr_en = 1'b1;
            tmr_load = 1'b1;
            tmr_val = TIMER_W'(SETTLE_CYC - 1);
            nxt_state = ST_SETTLE;
          end
        end
      end
    endcase
    // Release start: sync off, flags clocked, buffer strobe
    if (nxt_state == ST_RELEASE && state_ff != ST_RELEASE) begin
      nxt_master_sync = 1'b0;
      nxt_strobe = 1'b1;
      if (control_ff[CTL_SINGLE_BIT] || transfer_error_bit) begin
        nxt_second = 1'b1;
      end else if (hold_active) begin
        nxt_second = 1'b0; // Held clear in hold, no toggling
      end else begin
        nxt_second = ~second_ff;
      end
      nxt_next = hold_active | word_ready;
    end
    // Out of ownership or on hard errors the flag is held set
    if (!owner_ff || nonexistent_memory_flag || word_count_overflow || exception_stop) begin
      nxt_second = 1'b1;
    end
    // Other errors also mark a transfer error
    if (bus_parity_error || compare_mismatch_error) begin
      nxt_terr = 1'b1;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      master_sync_ff <= 1'b0;
      addr_en_ff <= 1'b0;
      busy_ff <= 1'b0;
      owner_ff <= 1'b0;
      sel_ack_ff <= 1'b0;
      release_ff <= 1'b0;
      strobe_ff <= 1'b0;
      second_ff <= 1'b1;
      next_ff <= 1'b0;
      nonexistent_memory_flag <= 1'b0;
      transfer_error_bit <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      master_sync_ff <= nxt_master_sync;
      addr_en_ff <= nxt_addr_en;
      busy_ff <= nxt_busy;
      owner_ff <= nxt_owner;
      sel_ack_ff <= nxt_sel_ack;
      release_ff <= nxt_release;
      strobe_ff <= nxt_strobe;
      second_ff <= nxt_second;
      next_ff <= nxt_next;
      nonexistent_memory_flag <= nxt_nxm;
      transfer_error_bit <= nxt_terr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register port

  // Zero-wait slave: read data prepared in the address phase
  always_comb begin
    logic take;
    take = hsel & htrans[1] & hready;
    nxt_wr_pend = take & hwrite;
    nxt_wr_addr = take ? haddr[7:0] : wr_addr_ff;
    nxt_rdata = rdata_ff;
    nxt_control = control_ff;
    start_cmd = 1'b0;
    error_clear_strobe = 1'b0;
    if (take && !hwrite) begin
      nxt_rdata = 32'h0000_0000; // Unmapped and command read as zero
      unique case (haddr[7:0])
        OFS_CONTROL: nxt_rdata[CTL_W-1:0] = control_ff;
        OFS_FIRST_STATUS: begin
          nxt_rdata[FCS_BUSY_BIT] = busy_ff;
          nxt_rdata[FCS_OWNER_BIT] = owner_ff;
          nxt_rdata[FCS_ERROR_BIT] = transfer_error_bit;
        end
        OFS_SECOND_STATUS: nxt_rdata[SCS_NXM_BIT] = nonexistent_memory_flag;
        default: ;
      endcase
    end
    // Data phase of a write
    if (wr_pend_ff) begin
      if (wr_addr_ff == OFS_CONTROL) begin
        nxt_control = hwdata[CTL_W-1:0];
      end
      if (wr_addr_ff == OFS_COMMAND) begin
        start_cmd = hwdata[CMD_START_BIT];
        error_clear_strobe = hwdata[CMD_CLEAR_BIT];
      end
    end
  end

  // Register port flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control_ff <= CONTROL_RESET;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff <= 32'h0000_0000;
    end else begin
      control_ff <= nxt_control;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  // Never stalls, never errors
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign master_sync = master_sync_ff;
  assign address_drive_enable = addr_en_ff;
  assign bus_busy = busy_ff;
  assign bus_owner_flag = owner_ff;
  assign sel_ack = sel_ack_ff;
  assign busy_release = release_ff;
  assign buffer_load_strobe = strobe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_deskew_then_release;
    (state_ff == ST_DESKEW)[*5] ##1 (state_ff == ST_RELEASE);
  endsequence
  sequence s_release_then_end;
    (state_ff == ST_RELEASE && !master_sync_ff)[*3] ##1 (state_ff == ST_END);
  endsequence

  a_timeout_sets_flag: assert property (
    state_ff == ST_REPLY && tmr_expired && !reply_seen |=> nonexistent_memory_flag && transfer_error_bit)
    else $error("timeout did not flag missing memory");
  a_flag_raises_error: assert property (
    $rose(nonexistent_memory_flag) |-> transfer_error_bit)
    else $error("missing memory without transfer error");
  a_reply_cancels: assert property (
    state_ff == ST_REPLY && reply_seen |=> state_ff != ST_REPLY && !$rose(nonexistent_memory_flag))
    else $error("reply did not cancel timeout");
  a_flag_sticky: assert property (
    nonexistent_memory_flag && !error_clear_strobe |=> nonexistent_memory_flag)
    else $error("missing memory flag dropped without clear");
  a_write_deskew: assert property (
    state_ff == ST_REPLY && reply_seen && !is_read |=> s_deskew_then_release)
    else $error("data deskew length wrong");
  a_release_length: assert property (
    state_ff != ST_RELEASE ##1 state_ff == ST_RELEASE |-> s_release_then_end)
    else $error("release interval wrong");
  a_address_held: assert property (
    state_ff == ST_RELEASE |-> address_drive_enable && bus_busy)
    else $error("address or busy lost in release");
  a_end_drops_address: assert property (
    state_ff == ST_END |-> !address_drive_enable)
    else $error("address still driven at end of cycle");
  a_read_no_deskew: assert property (
    state_ff == ST_REPLY && reply_seen && is_read |=> state_ff == ST_RELEASE && buffer_load_strobe)
    else $error("read did not skip deskew");
  a_idle_second_set: assert property (
    !owner_ff |=> second_ff)
    else $error("second flag not forced while idle");
  a_owner_clears_ack: assert property (
    $rose(owner_ff) |-> !sel_ack_ff)
    else $error("acknowledge kept after ownership");
  a_settle_first: assert property (
    $rose(master_sync_ff) |-> $past(address_drive_enable, 8))
    else $error("master sync before address settled");
endmodule // bus_master_cycle_sequencer

// *** rtl/bus_seq_pkg.sv ***
// Shared constants and types for the bus cycle sequencer
package bus_seq_pkg;
  // Clock and interval lengths in ns
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETTLE_NS = 200;
  localparam int REPLY_TIMEOUT_NS = 10000;
  localparam int DATA_DESKEW_NS = 125;
  localparam int SYNC_RELEASE_NS = 75;
  localparam int END_CYCLE_NS = 200;
  // Least times round up, the reply timeout is a longest time and rounds down
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int DATA_DESKEW_CYC = (DATA_DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_RELEASE_CYC = (SYNC_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int END_CYCLE_CYC = (END_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_FIRST_STATUS = 8'h08;
  localparam logic [7:0] OFS_SECOND_STATUS = 8'h0C;
  // Control register fields
  localparam int CTL_FN_LSB = 0;
  localparam int CTL_HOLD_BIT = 2;
  localparam int CTL_SINGLE_BIT = 3;
  localparam int CTL_BUSB_BIT = 4;
  localparam int CTL_W = 5;
  localparam logic [CTL_W-1:0] CONTROL_RESET = 5'h00;
  // Command register strobes
  localparam int CMD_START_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  // Status fields
  localparam int FCS_BUSY_BIT = 0;
  localparam int FCS_OWNER_BIT = 1;
  localparam int FCS_ERROR_BIT = 14;
  localparam int SCS_NXM_BIT = 11;
  // Function codes
  localparam logic [1:0] FN_WRITE = 2'h0;
  localparam logic [1:0] FN_WRITE_CHECK = 2'h1;
  localparam logic [1:0] FN_READ = 2'h2;
  // Sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_REPLY, ST_DESKEW, ST_RELEASE, ST_END} seq_state_e;
endpackage

// *** rtl/cycle_timer.sv ***
// Loadable down counter that times each phase of a memory cycle
`timescale 1ns/1ps
module cycle_timer
  import bus_seq_pkg::*;
#(
  parameter int W = TIMER_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Count has reached zero
  output logic expired
);
  logic [W-1:0] count_ff; // Cycles left
  logic [W-1:0] nxt_count;

  // Reload wins, otherwise count down to zero and hold
  always_comb begin
    nxt_count = count_ff;
    if (load) begin
      nxt_count = load_val;
    end else if (count_ff != '0) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign expired = (count_ff == '0);
endmodule // cycle_timer

// *** tb/memory_slave_model.sv ***
// Behavioural memory slave that answers master sync on the system bus
`timescale 1ns/1ps
module memory_slave_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Handshake from the sequencer
  input wire logic master_sync,
  // Scenario controls
  input wire logic mute,
  input wire logic [3:0] reply_delay,
  // Reply to the sequencer
  output logic slave_sync
);
  ////////////////////////////////////////////////////////////////////////////////
  // Reply counter, counts cycles since master sync was seen
  logic [3:0] wait_ff;

  // Reply after a chosen delay; a muted slave models missing memory
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slave_sync <= 1'b0;
      wait_ff <= 4'h0;
    end else if (!master_sync) begin
      // Drop the reply as soon as master sync goes away
      slave_sync <= 1'b0;
      wait_ff <= 4'h0;
    end else if (!mute && !slave_sync) begin
      if (wait_ff == reply_delay) begin
        slave_sync <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule // memory_slave_model

// *** tb/tb.sv ***
// Self-checking testbench for the bus cycle sequencer
`timescale 1ns/1ps
module tb;
  import bus_seq_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, reset and design inputs
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic input_ready = 1'b0;
  logic output_ready = 1'b0;
  logic bus_parity_error = 1'b0;
  logic compare_mismatch_error = 1'b0;
  logic word_count_overflow = 1'b0;
  logic exception_stop = 1'b0;
  // Design outputs
  logic hready, hreadyout, hresp, slave_sync, master_sync, address_drive_enable;
  logic bus_busy, bus_owner_flag, sel_ack, busy_release, buffer_load_strobe;
  logic [31:0] hrdata;
  logic [31:0] rd;
  // Partner controls
  logic mute = 1'b0;
  logic [3:0] reply_delay = 4'h2;
  // Bookkeeping; event times are cycle numbers
  int err_count = 0;
  int tests_run = 0;
  int ovf_at = 0;
  int cyc = 0, t_adr_rise = 0, t_adr_fall = 0, t_ms_rise = 0, t_ms_fall = 0, t_ss_rise = 0;
  int t_strobe = 0, t_sel = 0, t_own = 0, n_ms = 0, n_rel = 0, gap = 0;
  logic ms_q = 1'b0, ss_q = 1'b0, adr_q = 1'b0, own_q = 1'b0;

  // 40 MHz clock; the one slave's ready is the bus ready
  always #12.5 clock = ~clock;
  assign hready = hreadyout;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and far-side model
  bus_master_cycle_sequencer bus_master_cycle_sequencer_i (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .slave_sync(slave_sync), .master_sync(master_sync),
    .address_drive_enable(address_drive_enable), .bus_busy(bus_busy), .bus_owner_flag(bus_owner_flag),
    .sel_ack(sel_ack), .busy_release(busy_release), .buffer_load_strobe(buffer_load_strobe),
    .input_ready(input_ready), .output_ready(output_ready), .bus_parity_error(bus_parity_error),
    .compare_mismatch_error(compare_mismatch_error), .word_count_overflow(word_count_overflow),
    .exception_stop(exception_stop)
  );
  memory_slave_model memory_slave_model_i (
    .clock(clock), .rst(rst), .master_sync(master_sync), .mute(mute),
    .reply_delay(reply_delay), .slave_sync(slave_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Edge monitor, sampled mid-cycle so every flop has settled
  always @(negedge clock) begin
    cyc++;
    if (address_drive_enable && !adr_q) begin
      t_adr_rise = cyc;
      gap = cyc - t_adr_fall;
    end
    if (!address_drive_enable && adr_q) t_adr_fall = cyc;
    if (master_sync && !ms_q) begin
      t_ms_rise = cyc;
      n_ms++;
    end
    if (!master_sync && ms_q) t_ms_fall = cyc;
    if (slave_sync && !ss_q) t_ss_rise = cyc;
    if (buffer_load_strobe) t_strobe = cyc;
    if (sel_ack) t_sel = cyc;
    if (bus_owner_flag && !own_q) t_own = cyc;
    if (busy_release) n_rel++;
    ms_q = master_sync;
    ss_q = slave_sync;
    adr_q = address_drive_enable;
    own_q = bus_owner_flag;
  end

  // Word count runs out once the chosen number of cycles has started
  always @(posedge clock) word_count_overflow <= (ovf_at != 0) && (n_ms >= ovf_at);

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One single AHB-Lite transfer; holds each phase until ready is sampled high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    ahb(1'b0, a, 32'h0000_0000, rd);
    check(name, rd, exp);
  endtask

  // Start one ownership period and count its memory cycles
  task automatic run(input logic [31:0] ctl, input int exp_cyc, input string name);
    int n0;
    int lim;
    bus_wr(OFS_CONTROL, ctl);
    n_ms = 0;
    n0 = n_rel;
    bus_wr(OFS_COMMAND, 32'h0000_0001);
    lim = 0;
    while (n_rel == n0 && lim < 5000) begin
      @(posedge clock);
      lim++;
    end
    @(negedge clock);
    // A period that never ends counts as a mismatch
    check("period ended", {31'h0000_0000, n_rel != n0}, 32'h0000_0001);
    check(name, 32'(n_ms), 32'(exp_cyc));
    check("bus busy after end", {31'h0000_0000, bus_busy}, 32'h0000_0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  localparam logic [31:0] SINGLE = 32'h0000_0001 << CTL_SINGLE_BIT;
  localparam logic [31:0] HOLD = 32'h0000_0001 << CTL_HOLD_BIT;
  localparam logic [31:0] BUSB = 32'h0000_0001 << CTL_BUSB_BIT;

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    // Reset values, access kinds and an unmapped word
    bus_rd(OFS_FIRST_STATUS, 32'h0000_0000, "first status at reset");
    bus_rd(OFS_SECOND_STATUS, 32'h0000_0000, "second status at reset");
    bus_wr(OFS_CONTROL, 32'hFFFF_FFFF);
    bus_rd(OFS_CONTROL, 32'h0000_001F, "control width");
    bus_rd(OFS_COMMAND, 32'h0000_0000, "command reads zero");
    bus_rd(8'h10, 32'h0000_0000, "unmapped word");
    // Every function once as a single cycle, with prompt and slow replies
    for (int f = 0; f < 3; f++) begin
      reply_delay <= 4'(f * 3);
      run(32'(f) | SINGLE, 1, "single option cycles");
      check("reply to sync off", 32'(t_ms_fall - t_ss_rise), 32'((f == 32'(FN_READ)) ? 3 : 3 + DATA_DESKEW_CYC));
      check("address settle", 32'(t_ms_rise - t_adr_rise), 32'(SETTLE_CYC));
      check("load strobe time", 32'(t_strobe), 32'(t_ms_fall));
      check("release length", 32'(t_adr_fall - t_ms_fall), 32'(SYNC_RELEASE_CYC));
      check("ack before owner", 32'(t_own - t_sel), 32'h0000_0001);
      bus_rd(OFS_SECOND_STATUS, 32'h0000_0000, "no timeout flag");
    end
    // Back-to-back pair when a word is ready, one cycle when none is
    input_ready <= 1'b1;
    run(32'(FN_WRITE), 2, "pair with word ready");
    check("end of cycle gap", 32'(gap), 32'(END_CYCLE_CYC));
    input_ready <= 1'b0;
    run(32'(FN_WRITE), 1, "no word ready");
    // Parity, compare and exception stop errors each end the period after one cycle
    output_ready <= 1'b1;
    for (int e = 0; e < 3; e++) begin
      {bus_parity_error, compare_mismatch_error, exception_stop} <= 3'b100 >> e;
      run(32'(FN_WRITE_CHECK), 1, "error ends period");
      {bus_parity_error, compare_mismatch_error, exception_stop} <= 3'b000;
      bus_wr(OFS_COMMAND, 32'h0000_0002);
    end
    // Hold mode only counts with the second bus and no single option
    run(32'(FN_READ) | HOLD, 2, "hold without second bus");
    run(32'(FN_READ) | HOLD | SINGLE | BUSB, 1, "hold with single option");
    ovf_at = 3;
    run(32'(FN_READ) | HOLD | BUSB, 3, "hold until overflow");
    ovf_at = 0;
    // Missing memory: timeout, flags, and the missing memory flag kept until cleared
    output_ready <= 1'b0;
    mute <= 1'b1;
    run(32'(FN_WRITE) | SINGLE, 1, "timeout cycle");
    check("timeout window", 32'((t_ms_fall - t_ms_rise >= REPLY_TIMEOUT_CYC) &&
      (t_ms_fall - t_ms_rise <= REPLY_TIMEOUT_CYC + DATA_DESKEW_CYC + 2)), 32'h0000_0001);
    bus_rd(OFS_SECOND_STATUS, 32'h0000_0800, "missing memory flag");
    bus_rd(OFS_FIRST_STATUS, 32'h0000_4000, "transfer error bit");
    repeat (40) @(posedge clock);
    bus_rd(OFS_SECOND_STATUS, 32'h0000_0800, "flag kept");
    mute <= 1'b0;
    bus_wr(OFS_COMMAND, 32'h0000_0002);
    bus_rd(OFS_SECOND_STATUS, 32'h0000_0000, "flag cleared");
    wrap_up();
  end

  // Watchdog, well beyond the roughly one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    wrap_up();
  end
endmodule // tb
